// [inc/power_good_map.svh]
// register offsets, field positions, reset values and timing counts of the power-good register bank
// assumes a 100 MHz system clock; included by the package and by the design modules
`ifndef POWER_GOOD_MAP_SVH
`define POWER_GOOD_MAP_SVH

`define LOAD_SELECT_ADDR        8'h25
`define LOAD_HIGH_ADDR          8'h26
`define LOAD_LOW_ADDR           8'h27
`define SRC_SELECT_ADDR         8'h28
`define BEHAV_CONFIG_ADDR       8'h29
`define FAULT_LATCH_ADDR        8'h2A

`define LOAD_SELECT_RESET       8'h00
`define LOAD_CURRENT_RESET      10'h000
`define SRC_SELECT_RESET        8'h00
`define BEHAV_CONFIG_RESET      8'h00
`define FAULT_LATCH_RESET       4'h0
`define FAULT_RESV_RESET        4'h0
`define LOAD_FULL_SCALE         10'h3FF

`define HALF_DELAY_BIT          3'h7
`define MERGE_IRQ_BIT           3'h6
`define DEBOUNCE_SEL_BIT        3'h5
`define LATCH_MODE_BIT          3'h4
`define WINDOW_SEL_BIT          3'h2
`define DRIVER_TYPE_BIT         3'h1
`define POLARITY_BIT            3'h0

`define SRC_MASKED              2'h0
`define SRC_VOLTAGE             2'h1
`define SRC_VOLTAGE_ILIM        2'h3

`define SYS_CLK_MHZ             100
`define OK_SHORT_DEBOUNCE_NS    4000
`define OK_LONG_DEBOUNCE_US     11000
`define STEP_FULL_US            500
`define STEP_FULL_DOUBLE_US     1000
`define STEP_HALF_US            320
`define STEP_HALF_DOUBLE_US     640
`define OK_SHORT_DEBOUNCE_CYCLES ((`OK_SHORT_DEBOUNCE_NS * `SYS_CLK_MHZ + 999) / 1000)
`define OK_LONG_DEBOUNCE_CYCLES (`OK_LONG_DEBOUNCE_US * `SYS_CLK_MHZ)
`define STEP_FULL_CYCLES        (`STEP_FULL_US * `SYS_CLK_MHZ)
`define STEP_FULL_DOUBLE_CYCLES (`STEP_FULL_DOUBLE_US * `SYS_CLK_MHZ)
`define STEP_HALF_CYCLES        (`STEP_HALF_US * `SYS_CLK_MHZ)
`define STEP_HALF_DOUBLE_CYCLES (`STEP_HALF_DOUBLE_US * `SYS_CLK_MHZ)

`define DEB_COUNT_W             21
`define STEP_COUNT_W            17

`endif

// [inc/power_good_pkg.sv]
// types shared by the power-good register bank and its debounce filter
// widths come from the map header
`include "power_good_map.svh"

package power_good_pkg;

  typedef enum logic {
    MEAS_IDLE,
    MEAS_WAIT
  } meas_state_t;

  typedef struct packed {
    logic [3:0] uvAbove;
    logic [3:0] ovBelow;
    logic [3:0] ilimHit;
  } reg_status_t;

  typedef struct packed {
    logic [`DEB_COUNT_W-1:0] count;
    logic                    valid;
  } deb_state_t;

  typedef struct packed {
    logic [7:0]               loadSel;
    logic [7:0]               srcSel;
    logic [7:0]               behav;
    logic [3:0]               faultResv;
    logic [3:0]               faultFlags;
    logic [9:0]               loadCurrent;
    meas_state_t              measState;
    logic                     measStart;
    reg_status_t              sync1;
    reg_status_t              sync2;
    reg_status_t              sync3;
    reg_status_t              stable;
    logic [`STEP_COUNT_W-1:0] stepCount;
    logic                     stepTick;
    logic                     irqN;
    logic                     okOut;
    logic                     okOe;
    logic [7:0]               rdData;
  } ctrl_state_t;

endpackage

// [core/ok_debounce.sv]
// debounce of the combined regulator-valid level; only the rising edge is delayed
// assumes rawValid is already synchronised to sys_clk
`timescale 1ns/1ps
`include "power_good_map.svh"

module ok_debounce #(
  parameter int SHORT_CYCLES = `OK_SHORT_DEBOUNCE_CYCLES,
  parameter int LONG_CYCLES  = `OK_LONG_DEBOUNCE_CYCLES
) (
  input  wire logic sys_clk,
  input  wire logic reset_n,
  input  wire logic rawValid,
  input  wire logic longSel,
  output logic      debValid
);

  power_good_pkg::deb_state_t state_q;
  power_good_pkg::deb_state_t state_d;
  logic [`DEB_COUNT_W-1:0]    target;

  always_comb begin
    state_d = state_q;
    target  = longSel ? `DEB_COUNT_W'(LONG_CYCLES) : `DEB_COUNT_W'(SHORT_CYCLES);
    if (!rawValid) begin
      // falling validity is passed on at once
      state_d.count = '0;
      state_d.valid = 1'b0;
    end else if (!state_q.valid) begin
      if (state_q.count + `DEB_COUNT_W'(1) >= target) begin
        state_d.valid = 1'b1;
      end else begin
        state_d.count = state_q.count + `DEB_COUNT_W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign debValid = state_q.valid;

endmodule

// [core/power_good_load_current_regs.sv]
// register bank for load-current readout and power-good configuration of a four-regulator controller
// assumes an upstream serial-bus engine presenting byte writes/reads as one-cycle strobes on sys_clk,
// a measurement engine on sys_clk, and regulator status pins from the analog domain
//
// Summary of operation
// - upper readout register low two bits hold current bits 9:8, 20 mA per count
// - lower readout register holds current bits 7:0, reset value zero
// - all-ones code means 20.46 A; larger results saturate instead of wrapping
// - per regulator source code 0 excludes, 1 voltage only, 3 voltage and current limit
// - source fields in one register, regulator three at 7:6 down to zero at 1:0
// - delay-step bit picks 0.5/1 ms or 0.32/0.64 ms; doubling bit picks member
// - merge bit set: irq line low on pending interrupt or regulator zero not good
// - debounce only on going valid: short few microseconds, or 11 ms when selected
// - latch mode clear follows live status; set follows latched fault flags
// - in latch mode output inactive while any latched fault flag is set
// - window bit clear: undervoltage only; set: overvoltage or undervoltage deasserts
// - driver bit clear drives push-pull; set only pulls low, open drain
// - polarity clear: high when valid; set: low when valid
// - each write of the measurement select register starts exactly one measurement
// - master selected sums master plus slaves; slave selected reports itself alone
// - latched fault flag clears only on fault register read while regulator valid
`timescale 1ns/1ps
`include "power_good_map.svh"

module power_good_load_current_regs #(
  parameter int SHORT_DEBOUNCE_CYCLES   = `OK_SHORT_DEBOUNCE_CYCLES,
  parameter int LONG_DEBOUNCE_CYCLES    = `OK_LONG_DEBOUNCE_CYCLES,
  parameter int STEP_FULL_CYCLES        = `STEP_FULL_CYCLES,
  parameter int STEP_FULL_DOUBLE_CYCLES = `STEP_FULL_DOUBLE_CYCLES,
  parameter int STEP_HALF_CYCLES        = `STEP_HALF_CYCLES,
  parameter int STEP_HALF_DOUBLE_CYCLES = `STEP_HALF_DOUBLE_CYCLES
) (
  input  wire logic                        sys_clk,
  input  wire logic                        reset_n,
  input  wire logic [7:0]                  regAddr,
  input  wire logic [7:0]                  regWrData,
  input  wire logic                        regWrEn,
  input  wire logic                        regRdEn,
  output logic      [7:0]                  regRdData,
  input  wire power_good_pkg::reg_status_t regStatus,
  input  wire logic                        intPending,
  input  wire logic                        doubleDelay,
  input  wire logic [3:0]                  phaseIsMaster,
  input  wire logic [39:0]                 phaseCurrent,
  input  wire logic                        measDone,
  output logic                             measStart,
  output logic      [1:0]                  measRegSel,
  output logic                             delayStepTick,
  output logic                             irqLineLowActiveN,
  output logic                             powerOkOutput,
  output logic                             powerOkOe
);

  power_good_pkg::ctrl_state_t state_q;
  power_good_pkg::ctrl_state_t state_d;
  logic [3:0]                  regValid;
  logic                        allValid;
  logic                        debValid;
  logic                        good;
  logic                        pinLevel;
  logic [1:0]                  src;
  logic [`STEP_COUNT_W-1:0]    stepPeriod;
  logic                        wrHit;
  logic                        rdHit;

  // sum of the selected phase and, for a master, the slaves that follow it up to the next master
  function automatic logic [11:0] groupSum(input logic [1:0] sel, input logic [3:0] masters,
                                           input logic [39:0] cur);
    logic [11:0] acc;
    logic        inGroup;
    acc     = 12'h000;
    inGroup = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (2'(i) == sel) begin
        inGroup = 1'b1;
      end else if (masters[i] || !masters[sel]) begin
        inGroup = 1'b0;
      end
      if (inGroup) begin
        acc = acc + {2'h0, cur[i*10 +: 10]};
      end
    end
    return acc;
  endfunction

  function automatic logic [9:0] saturate(input logic [11:0] value);
    return (value > {2'h0, `LOAD_FULL_SCALE}) ? `LOAD_FULL_SCALE : value[9:0];
  endfunction

  ok_debounce #(
    .SHORT_CYCLES (SHORT_DEBOUNCE_CYCLES),
    .LONG_CYCLES  (LONG_DEBOUNCE_CYCLES)
  ) u_debounce (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .rawValid (allValid),
    .longSel  (state_q.behav[`DEBOUNCE_SEL_BIT]),
    .debValid (debValid)
  );

  always_comb begin
    for (int r = 0; r < 4; r++) begin
      src = state_q.srcSel[r*2 +: 2];
      case (src)
        `SRC_MASKED: begin
          regValid[r] = 1'b1;
        end
        `SRC_VOLTAGE_ILIM: begin
          regValid[r] = state_q.stable.uvAbove[r] &
                        (state_q.stable.ovBelow[r] | ~state_q.behav[`WINDOW_SEL_BIT]) &
                        ~state_q.stable.ilimHit[r];
        end
        default: begin
          // reserved code 2 has no branch of its own, so it falls back to voltage only
          regValid[r] = state_q.stable.uvAbove[r] &
                        (state_q.stable.ovBelow[r] | ~state_q.behav[`WINDOW_SEL_BIT]);
        end
      endcase
    end
  end

  assign allValid = &regValid;
  assign wrHit    = regWrEn;
  assign rdHit    = regRdEn;

  always_comb begin
    state_d           = state_q;
    state_d.measStart = 1'b0;
    state_d.stepTick  = 1'b0;

    // pin synchroniser: a bit changes once the second and third stages agree
    state_d.sync1  = regStatus;
    state_d.sync2  = state_q.sync1;
    state_d.sync3  = state_q.sync2;
    state_d.stable = (state_q.sync2 & state_q.sync3) | (state_q.stable & (state_q.sync2 ^ state_q.sync3));

    if (wrHit) begin
      case (regAddr)
        `LOAD_SELECT_ADDR: begin
          state_d.loadSel   = regWrData;
          state_d.measStart = 1'b1;
          state_d.measState = power_good_pkg::MEAS_WAIT;
        end
        `SRC_SELECT_ADDR: begin
          state_d.srcSel = regWrData;
        end
        `BEHAV_CONFIG_ADDR: begin
          state_d.behav = regWrData;
        end
        `FAULT_LATCH_ADDR: begin
          state_d.faultResv = regWrData[7:4];
        end
        default: begin
          // readout registers and unmapped offsets ignore writes
          state_d.loadSel = state_q.loadSel;
        end
      endcase
    end

    // a new write restarts the wait, so an older result never lands after a newer request
    case (state_q.measState)
      power_good_pkg::MEAS_WAIT: begin
        if (measDone && !state_q.measStart && !(wrHit && regAddr == `LOAD_SELECT_ADDR)) begin
          state_d.loadCurrent = saturate(groupSum(state_q.loadSel[1:0], phaseIsMaster, phaseCurrent));
          state_d.measState   = power_good_pkg::MEAS_IDLE;
        end
      end
      default: begin
        state_d.measState = state_d.measState;
      end
    endcase

    // latched faults: a fault present this cycle always wins over the read clear
    state_d.faultFlags = state_q.faultFlags & ~((rdHit && regAddr == `FAULT_LATCH_ADDR) ? regValid : 4'h0);
    state_d.faultFlags = state_d.faultFlags | ~regValid;

    if (rdHit) begin
      case (regAddr)
        `LOAD_SELECT_ADDR:  state_d.rdData = state_q.loadSel;
        `LOAD_HIGH_ADDR:    state_d.rdData = {6'h00, state_q.loadCurrent[9:8]};
        `LOAD_LOW_ADDR:     state_d.rdData = state_q.loadCurrent[7:0];
        `SRC_SELECT_ADDR:   state_d.rdData = state_q.srcSel;
        `BEHAV_CONFIG_ADDR: state_d.rdData = state_q.behav;
        `FAULT_LATCH_ADDR:  state_d.rdData = {state_q.faultResv, state_q.faultFlags};
        default:            state_d.rdData = 8'h00;
      endcase
    end

    // delay step divider
    case ({state_q.behav[`HALF_DELAY_BIT], doubleDelay})
      2'b00:   stepPeriod = `STEP_COUNT_W'(STEP_FULL_CYCLES);
      2'b01:   stepPeriod = `STEP_COUNT_W'(STEP_FULL_DOUBLE_CYCLES);
      2'b10:   stepPeriod = `STEP_COUNT_W'(STEP_HALF_CYCLES);
      default: stepPeriod = `STEP_COUNT_W'(STEP_HALF_DOUBLE_CYCLES);
    endcase
    if (state_q.stepCount + `STEP_COUNT_W'(1) >= stepPeriod) begin
      state_d.stepCount = '0;
      state_d.stepTick  = 1'b1;
    end else begin
      state_d.stepCount = state_q.stepCount + `STEP_COUNT_W'(1);
    end

    good = state_q.behav[`LATCH_MODE_BIT] ? ~|state_q.faultFlags : debValid;
    pinLevel = good ^ state_q.behav[`POLARITY_BIT];
    if (state_q.behav[`DRIVER_TYPE_BIT]) begin
      state_d.okOut = 1'b0;
      state_d.okOe  = ~pinLevel;
    end else begin
      state_d.okOut = pinLevel;
      state_d.okOe  = 1'b1;
    end
    state_d.irqN = ~(intPending | (state_q.behav[`MERGE_IRQ_BIT] & ~regValid[0]));
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_q             <= '0;
      state_q.loadSel     <= `LOAD_SELECT_RESET;
      state_q.srcSel      <= `SRC_SELECT_RESET;
      state_q.behav       <= `BEHAV_CONFIG_RESET;
      state_q.faultResv   <= `FAULT_RESV_RESET;
      state_q.faultFlags  <= `FAULT_LATCH_RESET;
      state_q.loadCurrent <= `LOAD_CURRENT_RESET;
      state_q.measState   <= power_good_pkg::MEAS_IDLE;
      state_q.irqN        <= 1'b1;
      state_q.okOe        <= 1'b1;
    end else begin
      state_q <= state_d;
    end
  end

  assign regRdData         = state_q.rdData;
  assign measStart         = state_q.measStart;
  assign measRegSel        = state_q.loadSel[1:0];
  assign delayStepTick     = state_q.stepTick;
  assign irqLineLowActiveN = state_q.irqN;
  assign powerOkOutput     = state_q.okOut;
  assign powerOkOe         = state_q.okOe;

endmodule

// [tb/meas_engine_model.sv]
// behavioural measurement engine answering the register bank's start pulse
// assumes one sys_clk domain; result only qualified while measDone is high
`timescale 1ns/1ps

module meas_engine_model (
  input  wire logic        sys_clk,
  input  wire logic        measStart,
  input  wire logic [3:0]  latency,
  input  wire logic [39:0] codes,
  output logic             measDone,
  output logic      [39:0] phaseCurrent
);
  logic [3:0] left = 4'h0;

  initial begin
    measDone = 1'b0;
    phaseCurrent = 40'h0;
  end

  always @(posedge sys_clk) begin
    measDone <= 1'b0;
    // scrambled outside the done pulse so a late sample shows up
    phaseCurrent <= ~codes;
    if (measStart) begin
      left <= latency;
    end else if (left != 4'h0) begin
      left <= left - 4'h1;
    end
    if (!measStart && left == 4'h1) begin
      measDone <= 1'b1;
      phaseCurrent <= codes;
    end
  end
endmodule

// [tb/power_good_load_current_regs_assertions.sv]
// port assertions for the power-good register bank
// assumes the bench's short delay-step parameters (shortest step 5 cycles)
`timescale 1ns/1ps

module power_good_load_current_regs_assertions (
  input wire logic       sys_clk,
  input wire logic       reset_n,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic       regWrEn,
  input wire logic       regRdEn,
  input wire logic [7:0] regRdData,
  input wire logic       intPending,
  input wire logic       measStart,
  input wire logic [1:0] measRegSel,
  input wire logic       delayStepTick,
  input wire logic       irqLineLowActiveN,
  input wire logic       powerOkOutput,
  input wire logic       powerOkOe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  chk_meas_start_go: assert property (regWrEn && regAddr == 8'h25 |=> measStart)
    else $error("no start pulse after select write");
  chk_meas_start_once: assert property (!(regWrEn && regAddr == 8'h25) |=> !measStart)
    else $error("start pulse without select write");
  chk_meas_sel: assert property (regWrEn && regAddr == 8'h25 |=> measRegSel == $past(regWrData[1:0]))
    else $error("selected regulator not taken from write");
  chk_irq_pending: assert property (intPending |=> !irqLineLowActiveN)
    else $error("irq line high with interrupt pending");
  chk_od_release: assert property (!powerOkOe |-> !powerOkOutput)
    else $error("released pin carries a high level");
  chk_high_resv: assert property (regRdEn && regAddr == 8'h26 |=> regRdData[7:2] == 6'h00)
    else $error("reserved readout bits not zero");
  chk_unmapped_zero: assert property (regRdEn && regAddr == 8'h30 |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  // a step tick is a single pulse; steps are never shorter than a few cycles
  chk_step_gap: assert property (delayStepTick |=> !delayStepTick [*3])
    else $error("delay step ticks too close");
  chk_rd_hold: assert property (!regRdEn |=> $stable(regRdData))
    else $error("read data changed without a read");
endmodule

bind power_good_load_current_regs power_good_load_current_regs_assertions u_chk (.*);

// [tb/power_good_load_current_regs_tb.sv]
// self-checking bench for the power-good register bank
// assumes the model and checker files are compiled first
`timescale 1ns/1ps

module power_good_load_current_regs_tb;
  logic                        sys_clk, reset_n, regWrEn, regRdEn, intPending, doubleDelay;
  logic                        measDone, measStart, delayStepTick, irqLineLowActiveN;
  logic                        powerOkOutput, powerOkOe;
  logic [7:0]                  regAddr, regWrData, regRdData;
  logic [1:0]                  measRegSel;
  logic [3:0]                  phaseIsMaster, latency;
  logic [39:0]                 phaseCurrent, codes;
  power_good_pkg::reg_status_t regStatus;
  int                          mismatches = 0;
  int                          checksDone = 0;

  power_good_load_current_regs #(
    .LONG_DEBOUNCE_CYCLES(20), .STEP_FULL_CYCLES(8),
    .STEP_FULL_DOUBLE_CYCLES(16), .STEP_HALF_CYCLES(5), .STEP_HALF_DOUBLE_CYCLES(10)
  ) u_dut (
    .sys_clk, .reset_n, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData, .regStatus,
    .intPending, .doubleDelay, .phaseIsMaster, .phaseCurrent, .measDone, .measStart,
    .measRegSel, .delayStepTick, .irqLineLowActiveN, .powerOkOutput, .powerOkOe
  );

  meas_engine_model u_meas (.sys_clk, .measStart, .latency, .codes, .measDone, .phaseCurrent);

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checksDone++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regWrEn <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge sys_clk);
    regWrEn <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    regRdEn <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRdEn <= 1'b0;
    #1 d = regRdData;
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    check(16'(v), 16'(e));
  endtask

  task automatic meas(input logic [3:0] m, input logic [39:0] c, input logic [1:0] s,
                      input logic [3:0] l, input logic [9:0] e);
    logic [7:0] hi, lo;
    phaseIsMaster <= m;
    codes <= c;
    latency <= l;
    wr(8'h25, {6'h00, s});
    repeat (14) @(posedge sys_clk);
    rd(8'h26, hi);
    rd(8'h27, lo);
    check({hi, lo}, {6'h00, e});
  endtask

  task automatic okCase(input logic [7:0] src, input logic [7:0] cfg, input logic [11:0] st,
                        input logic [1:0] e);
    wr(8'h28, src);
    wr(8'h29, cfg);
    regStatus <= st;
    // short debounce keeps its default of 400 cycles, plus synchroniser and output flops
    repeat (410) @(posedge sys_clk);
    check(16'({powerOkOutput, powerOkOe}), 16'(e));
    rdChk(8'h28, src);
  endtask

  task automatic testReset;
    rdChk(8'h26, 8'h00);
    rdChk(8'h27, 8'h00);
    rdChk(8'h30, 8'h00);
    $display("reset test done");
  endtask

  task automatic testMeas;
    meas(4'hF, {10'h000, 10'h2A5, 10'h000, 10'h000}, 2'h2, 4'h1, 10'h2A5);
    wr(8'h27, 8'h5A);
    wr(8'h26, 8'hFF);
    rdChk(8'h27, 8'hA5);
    meas(4'h1, {10'h008, 10'h020, 10'h050, 10'h100}, 2'h0, 4'h9, 10'h178);
    meas(4'h1, {10'h008, 10'h020, 10'h050, 10'h100}, 2'h1, 4'h2, 10'h050);
    meas(4'h5, {10'h008, 10'h020, 10'h050, 10'h100}, 2'h0, 4'h5, 10'h150);
    meas(4'h1, {10'h000, 10'h000, 10'h200, 10'h300}, 2'h0, 4'h3, 10'h3FF);
    $display("measurement test done");
  endtask

  task automatic testOk;
    okCase(8'h00, 8'h00, 12'hFF0, 2'b11);
    okCase(8'hC0, 8'h00, 12'hFF8, 2'b01);
    okCase(8'h40, 8'h00, 12'hFF8, 2'b11);
    okCase(8'h40, 8'h00, 12'h7F0, 2'b01);
    okCase(8'h01, 8'h00, 12'hEF0, 2'b01);
    okCase(8'h40, 8'h00, 12'hEF0, 2'b11);
    okCase(8'h40, 8'h00, 12'hF70, 2'b11);
    okCase(8'h40, 8'h04, 12'hF70, 2'b01);
    okCase(8'h40, 8'h01, 12'hFF0, 2'b01);
    okCase(8'h40, 8'h01, 12'h7F0, 2'b11);
    okCase(8'h40, 8'h02, 12'hFF0, 2'b00);
    okCase(8'h40, 8'h02, 12'h7F0, 2'b01);
    $display("power good test done");
  endtask

  task automatic testDebounce;
    okCase(8'h40, 8'h20, 12'h7F0, 2'b01);
    regStatus <= 12'hFF0;
    repeat (16) @(posedge sys_clk);
    check(16'(powerOkOutput), 16'h0000);
    repeat (20) @(posedge sys_clk);
    check(16'(powerOkOutput), 16'h0001);
    regStatus <= 12'h7F0;
    repeat (10) @(posedge sys_clk);
    check(16'(powerOkOutput), 16'h0000);
    $display("debounce test done");
  endtask

  task automatic testLatch;
    logic [7:0] v;
    // flags gathered by earlier live-mode cases are cleared while every source is valid
    wr(8'h28, 8'h01);
    rd(8'h2A, v);
    okCase(8'h01, 8'h10, 12'hFF0, 2'b11);
    regStatus <= 12'hEF0;
    repeat (10) @(posedge sys_clk);
    rdChk(8'h2A, 8'h01);
    rdChk(8'h2A, 8'h01);
    regStatus <= 12'hFF0;
    repeat (20) @(posedge sys_clk);
    check(16'(powerOkOutput), 16'h0000);
    rdChk(8'h2A, 8'h01);
    rdChk(8'h2A, 8'h00);
    repeat (4) @(posedge sys_clk);
    check(16'(powerOkOutput), 16'h0001);
    $display("latch test done");
  endtask

  task automatic testIrq;
    okCase(8'h01, 8'h40, 12'hEF0, 2'b01);
    check(16'(irqLineLowActiveN), 16'h0000);
    okCase(8'h01, 8'h00, 12'hEF0, 2'b01);
    check(16'(irqLineLowActiveN), 16'h0001);
    intPending <= 1'b1;
    repeat (3) @(posedge sys_clk);
    check(16'(irqLineLowActiveN), 16'h0000);
    intPending <= 1'b0;
    $display("irq test done");
  endtask

  task automatic testStep;
    time t;
    int per [4] = '{8, 16, 5, 10};
    for (int i = 0; i < 4; i++) begin
      wr(8'h29, {i[1], 7'h00});
      doubleDelay <= i[0];
      repeat (2) @(posedge delayStepTick);
      t = $time;
      @(posedge delayStepTick);
      check(16'(($time - t) / 10), 16'(per[i]));
    end
    $display("delay step test done");
  endtask

  task automatic testDone;
    $display("checks %0d mismatches %0d", checksDone, mismatches);
    if (mismatches == 0 && checksDone > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  initial begin
    reset_n = 1'b0;
    {regWrEn, regRdEn, intPending, doubleDelay, regAddr, regWrData} = '0;
    {phaseIsMaster, codes, latency} = '0;
    regStatus = 12'hFF0;
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    testReset();
    testMeas();
    testOk();
    testDebounce();
    testLatch();
    testIrq();
    testStep();
    testDone();
  end

  // whole run is about seven thousand cycles
  initial begin
    #400000;
    mismatches++;
    testDone();
  end
endmodule
